//--- core/urfbd_top.sv
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module urfbd_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic rx_i,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic wait_q;
  logic go;
  logic wr_go;
  logic rd_go;
  logic [31:0] rdata_d;
  logic [7:0] line_q;
  logic [15:0] div_whole_q;
  logic [5:0] div_frac_q;
  logic [0:0] ctrl_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_en_q;
  logic [3:0] irq_ev;
  logic [3:0] irq_clr;
  logic [15:0] div_act_q;
  logic [5:0] frac_act_q;
  logic ovs_act_q;
  logic [15:0] base_cnt_q;
  logic [5:0] frac_acc_q;
  logic carry_q;
  logic [16:0] period;
  logic tick;
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic rx_q;
  urfbd_pkg::urfbd_state_t state_q;
  logic [3:0] samp_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic par_acc_q;
  logic par_err_q;
  logic frame_err_q;
  logic [3:0] samp_last;
  logic [3:0] samp_half;
  logic [2:0] bit_last;
  logic mid;
  logic par_bad;
  logic done;
  logic [9:0] mem_q [urfbd_pkg::QUEUE_DEPTH];
  logic [4:0] wp_q;
  logic [4:0] rp_q;
  logic [4:0] count;
  logic [4:0] cap;
  logic q_full;
  logic q_empty;
  logic push;
  logic pop;
  logic [7:0] data_al;

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, answer in the second
  // ----------------------------------------------------------------
  // The request is acted on at the edge it is first seen; waitrequest then
  // drops for one cycle so the master completes without a second action.
  assign go = wait_q && (avs_read_i || avs_write_i);
  assign wr_go = go && avs_write_i;
  assign rd_go = go && avs_read_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !go;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (avs_address_i == urfbd_pkg::OFS_RX_DATA) begin
      rdata_d[9:0] = q_empty ? 10'h000 : mem_q[rp_q[3:0]];
    end else if (avs_address_i == urfbd_pkg::OFS_FLAGS) begin
      rdata_d[urfbd_pkg::POS_FLAG_EMPTY] = q_empty;
      rdata_d[urfbd_pkg::POS_FLAG_FULL] = q_full;
    end else if (avs_address_i == urfbd_pkg::OFS_LINE_FMT) begin
      rdata_d[7:1] = line_q[7:1];
    end else if (avs_address_i == urfbd_pkg::OFS_DIV_WHOLE) begin
      rdata_d[15:0] = div_whole_q;
    end else if (avs_address_i == urfbd_pkg::OFS_DIV_FRAC) begin
      rdata_d[5:0] = div_frac_q;
    end else if (avs_address_i == urfbd_pkg::OFS_CTRL) begin
      rdata_d[0:0] = ctrl_q;
    end else if (avs_address_i == urfbd_pkg::OFS_IRQ_STAT) begin
      rdata_d[3:0] = irq_stat_q;
    end else if (avs_address_i == urfbd_pkg::OFS_IRQ_EN) begin
      rdata_d[3:0] = irq_en_q;
    end else begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata_o <= rdata_d;
    end
  end

  assign avs_waitrequest_o = wait_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_q <= urfbd_pkg::RST_LINE_FMT;
      div_whole_q <= urfbd_pkg::RST_DIV_WHOLE;
      div_frac_q <= urfbd_pkg::RST_DIV_FRAC;
      ctrl_q <= urfbd_pkg::RST_CTRL;
      irq_en_q <= urfbd_pkg::RST_IRQ_EN;
    end else if (wr_go) begin
      if (avs_address_i == urfbd_pkg::OFS_LINE_FMT) begin
        line_q <= 8'(merge_bytes({24'h000000, line_q}, avs_writedata_i,
                                 avs_byteenable_i) & 32'h0000_00FE);
      end else if (avs_address_i == urfbd_pkg::OFS_DIV_WHOLE) begin
        div_whole_q <= 16'(merge_bytes({16'h0000, div_whole_q}, avs_writedata_i,
                                       avs_byteenable_i));
      end else if (avs_address_i == urfbd_pkg::OFS_DIV_FRAC) begin
        div_frac_q <= 6'(merge_bytes({26'h0, div_frac_q}, avs_writedata_i,
                                     avs_byteenable_i));
      end else if (avs_address_i == urfbd_pkg::OFS_CTRL) begin
        ctrl_q <= 1'(merge_bytes({31'h0, ctrl_q}, avs_writedata_i,
                                 avs_byteenable_i));
      end else if (avs_address_i == urfbd_pkg::OFS_IRQ_EN) begin
        irq_en_q <= 4'(merge_bytes({28'h0, irq_en_q}, avs_writedata_i,
                                   avs_byteenable_i));
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_clr = (wr_go && avs_address_i == urfbd_pkg::OFS_IRQ_CLR &&
                    avs_byteenable_i[0]) ? avs_writedata_i[3:0] : 4'h0;

  always_comb begin
    irq_ev = 4'h0;
    irq_ev[urfbd_pkg::POS_IRQ_CHAR] = push && !q_full;
    irq_ev[urfbd_pkg::POS_IRQ_PARITY] = push && par_err_q;
    irq_ev[urfbd_pkg::POS_IRQ_FRAME] = push && (frame_err_q || !rx_q);
    irq_ev[urfbd_pkg::POS_IRQ_OVERRUN] = push && q_full;
  end

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      irq_o <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------
  // Software writes the divisor as clock / (oversampling * baud rate).
  // The active copy only follows the registers while no character is in
  // flight, so a rewrite never stretches or cuts a bit half way.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_act_q <= urfbd_pkg::RST_DIV_WHOLE;
      frac_act_q <= urfbd_pkg::RST_DIV_FRAC;
      ovs_act_q <= 1'b0;
    end else if (state_q == urfbd_pkg::ST_IDLE) begin
      div_act_q <= div_whole_q;
      frac_act_q <= div_frac_q;
      ovs_act_q <= ctrl_q[urfbd_pkg::POS_OVERSAMPLE];
    end
  end

  // Each tick period is the whole divisor, stretched by one cycle whenever
  // the accumulated fraction in sixty-fourths overflows.
  assign period = {1'b0, div_act_q} + {16'h0000, carry_q};
  assign tick = (div_act_q != 16'h0000) &&
                ({1'b0, base_cnt_q} + 17'h00001 >= period);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_cnt_q <= 16'h0000;
      frac_acc_q <= 6'h00;
      carry_q <= 1'b0;
    end else if (div_act_q == 16'h0000) begin
      base_cnt_q <= 16'h0000;
      frac_acc_q <= 6'h00;
      carry_q <= 1'b0;
    end else if (tick) begin
      base_cnt_q <= 16'h0000;
      {carry_q, frac_acc_q} <= {1'b0, frac_acc_q} + {1'b0, frac_act_q};
    end else begin
      base_cnt_q <= base_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Receive line synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      rx_q <= 1'b1;
    end else begin
      sync1_q <= rx_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        rx_q <= sync3_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame receiver
  // ----------------------------------------------------------------
  assign samp_last = ovs_act_q ? urfbd_pkg::OVS8_LAST : urfbd_pkg::OVS16_LAST;
  assign samp_half = ovs_act_q ? urfbd_pkg::OVS8_HALF : urfbd_pkg::OVS16_HALF;
  assign bit_last = urfbd_pkg::LEN_BASE_LAST +
                    {1'b0, line_q[urfbd_pkg::POS_LEN_LO +: 2]};
  assign mid = tick && (samp_q == samp_last);

  // Fixed parity compares the bit itself; otherwise the ones count of data
  // plus parity must be even or odd as picked.
  assign par_bad = (line_q[urfbd_pkg::POS_FIXED_PARITY] ? rx_q : (par_acc_q ^ rx_q))
                   != !line_q[urfbd_pkg::POS_EVEN_PICK];

  assign done = mid && ((state_q == urfbd_pkg::ST_STOP1 &&
                         !line_q[urfbd_pkg::POS_DOUBLE_STOP]) ||
                        state_q == urfbd_pkg::ST_STOP2);
  assign push = done;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= urfbd_pkg::ST_IDLE;
      samp_q <= 4'h0;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      par_acc_q <= 1'b0;
      par_err_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else begin
      if (tick) begin
        samp_q <= (samp_q == samp_last) ? 4'h0 : samp_q + 4'h1;
      end
      case (state_q)
        urfbd_pkg::ST_IDLE: begin
          samp_q <= 4'h0;
          if (!rx_q && div_act_q != 16'h0000) begin
            state_q <= urfbd_pkg::ST_START;
          end
        end
        urfbd_pkg::ST_START: begin
          if (tick && samp_q == samp_half) begin
            samp_q <= 4'h0;
            bit_q <= 3'h0;
            par_acc_q <= 1'b0;
            par_err_q <= 1'b0;
            frame_err_q <= 1'b0;
            state_q <= rx_q ? urfbd_pkg::ST_IDLE : urfbd_pkg::ST_DATA;
          end
        end
        urfbd_pkg::ST_DATA: begin
          if (mid) begin
            shift_q <= {rx_q, shift_q[7:1]};
            par_acc_q <= par_acc_q ^ rx_q;
            bit_q <= bit_q + 3'h1;
            if (bit_q == bit_last) begin
              state_q <= line_q[urfbd_pkg::POS_PARITY_ON] ? urfbd_pkg::ST_PARITY
                                                         : urfbd_pkg::ST_STOP1;
            end
          end
        end
        urfbd_pkg::ST_PARITY: begin
          if (mid) begin
            par_err_q <= par_bad;
            state_q <= urfbd_pkg::ST_STOP1;
          end
        end
        urfbd_pkg::ST_STOP1: begin
          if (mid) begin
            frame_err_q <= !rx_q;
            state_q <= line_q[urfbd_pkg::POS_DOUBLE_STOP] ? urfbd_pkg::ST_STOP2
                                                         : urfbd_pkg::ST_IDLE;
          end
        end
        urfbd_pkg::ST_STOP2: begin
          if (mid) begin
            frame_err_q <= frame_err_q || !rx_q;
            state_q <= urfbd_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= urfbd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive queue or holding register
  // ----------------------------------------------------------------
  // Character mode uses the same storage with a capacity of one, so a
  // second character before the read is an overrun and is dropped.
  assign count = wp_q - rp_q;
  assign cap = line_q[urfbd_pkg::POS_QUEUE_ON] ? urfbd_pkg::QUEUE_CAP_ON
                                              : urfbd_pkg::QUEUE_CAP_OFF;
  assign q_full = count >= cap;
  assign q_empty = (count == 5'h00);
  assign pop = rd_go && (avs_address_i == urfbd_pkg::OFS_RX_DATA) && !q_empty;
  assign data_al = shift_q >> (2'h3 - line_q[urfbd_pkg::POS_LEN_LO +: 2]);

  always_ff @(posedge clk_i) begin
    if (push && !q_full) begin
      mem_q[wp_q[3:0]] <= {par_err_q, frame_err_q || !rx_q, data_al};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q <= 5'h00;
      rp_q <= 5'h00;
    end else begin
      if (push && !q_full) begin
        wp_q <= wp_q + 5'h01;
      end
      if (pop) begin
        rp_q <= rp_q + 5'h01;
      end
    end
  end

endmodule

//--- core/urfbd_pkg.sv
package urfbd_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_RX_DATA = 7'h00;
  localparam logic [6:0] OFS_FLAGS = 7'h18;
  localparam logic [6:0] OFS_LINE_FMT = 7'h1C;
  localparam logic [6:0] OFS_DIV_WHOLE = 7'h24;
  localparam logic [6:0] OFS_DIV_FRAC = 7'h28;
  localparam logic [6:0] OFS_CTRL = 7'h30;
  localparam logic [6:0] OFS_IRQ_STAT = 7'h38;
  localparam logic [6:0] OFS_IRQ_EN = 7'h3C;
  localparam logic [6:0] OFS_IRQ_CLR = 7'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_PARITY_ON = 1;
  localparam int POS_EVEN_PICK = 2;
  localparam int POS_DOUBLE_STOP = 3;
  localparam int POS_QUEUE_ON = 4;
  localparam int POS_LEN_LO = 5;
  localparam int POS_FIXED_PARITY = 7;
  localparam int POS_OVERSAMPLE = 0;
  localparam int POS_FLAG_EMPTY = 4;
  localparam int POS_FLAG_FULL = 6;
  localparam int POS_DATA_FRAME = 8;
  localparam int POS_DATA_PARITY = 9;
  localparam int POS_IRQ_CHAR = 0;
  localparam int POS_IRQ_PARITY = 1;
  localparam int POS_IRQ_FRAME = 2;
  localparam int POS_IRQ_OVERRUN = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LINE_FMT = 8'h00;
  localparam logic [15:0] RST_DIV_WHOLE = 16'h0000;
  localparam logic [5:0] RST_DIV_FRAC = 6'h00;
  localparam logic [0:0] RST_CTRL = 1'h0;
  localparam logic [3:0] RST_IRQ_EN = 4'h0;

  // ----------------------------------------------------------------
  // Timing counts in oversample ticks and data bits
  // ----------------------------------------------------------------
  localparam logic [3:0] OVS16_LAST = 4'hF;
  localparam logic [3:0] OVS8_LAST = 4'h7;
  localparam logic [3:0] OVS16_HALF = 4'h7;
  localparam logic [3:0] OVS8_HALF = 4'h3;
  localparam logic [2:0] LEN_BASE_LAST = 3'h4;

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  localparam int QUEUE_DEPTH = 16;
  localparam logic [4:0] QUEUE_CAP_ON = 5'h10;
  localparam logic [4:0] QUEUE_CAP_OFF = 5'h01;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_START = 6'h02,
    ST_DATA = 6'h04,
    ST_PARITY = 6'h08,
    ST_STOP1 = 6'h10,
    ST_STOP2 = 6'h20
  } urfbd_state_t;

endpackage

//--- test/urfbd_chk.sv
`timescale 1ns/1ps
module urfbd_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic rx_i,
  input wire logic irq_o
);
  // ----------------------------------------
  // Shadow copies of written registers
  // ----------------------------------------
  logic [7:0] fmt_q;
  logic [15:0] div_q;
  logic wr_take;
  assign wr_take = avs_write_i && avs_waitrequest_o;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fmt_q <= 8'h00;
    end else if (wr_take && avs_byteenable_i[0] && avs_address_i == urfbd_pkg::OFS_LINE_FMT) begin
      fmt_q <= {avs_writedata_i[7:1], 1'b0};
    end
  end

  // Byte lanes are tracked apart, so a lane slip in the design shows up.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 16'h0000;
    end else if (wr_take && avs_address_i == urfbd_pkg::OFS_DIV_WHOLE) begin
      if (avs_byteenable_i[0]) begin
        div_q[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        div_q[15:8] <= avs_writedata_i[15:8];
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence req_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  sequence rd_take(logic [6:0] a);
    avs_read_i && avs_waitrequest_o && avs_address_i == a;
  endsequence

  req_answer_a: assert property (req_take |=> !avs_waitrequest_o)
    else $error("request not answered after one cycle");
  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  idle_wait_a: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("waitrequest dropped without request");
  data_hold_a: assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
    else $error("read data moved without a read");
  fmt_read_a: assert property (
    rd_take(urfbd_pkg::OFS_LINE_FMT) |=> avs_readdata_o == {24'h000000, fmt_q})
    else $error("line format readback differs");
  div_read_a: assert property (
    rd_take(urfbd_pkg::OFS_DIV_WHOLE) |=> avs_readdata_o == {16'h0000, div_q})
    else $error("divisor readback differs");
  clr_read_a: assert property (rd_take(urfbd_pkg::OFS_IRQ_CLR) |=> avs_readdata_o == 32'h00000000)
    else $error("clear register read nonzero");
  hole_read_a: assert property (avs_read_i && avs_waitrequest_o
    && avs_address_i > urfbd_pkg::OFS_IRQ_CLR |=> avs_readdata_o == 32'h00000000)
    else $error("unmapped read nonzero");
endmodule

bind urfbd_top urfbd_chk i_urfbd_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .rx_i(rx_i), .irq_o(irq_o)
);

//--- test/urfbd_tx_model.sv
`timescale 1ns/1ps
module urfbd_tx_model (
  input wire logic clk_i,
  output logic line_o
);
  // Line rests at mark level between frames.
  initial line_o = 1'b1;

  task automatic put_bit(input logic b, input int clks);
    line_o <= b;
    repeat (clks) @(posedge clk_i);
  endtask

  task automatic send(input logic [7:0] d, input int nbits, input logic pen, input logic even,
                      input logic fixed, input int stops, input logic bad_par,
                      input logic bad_stop, input int bclk);
    logic ones;
    ones = 1'b0;
    put_bit(1'b0, bclk);
    for (int i = 0; i < nbits; i++) begin
      put_bit(d[i], bclk);
      ones = ones ^ d[i];
    end
    if (pen) begin
      put_bit((fixed ? ~even : (even ? ones : ~ones)) ^ bad_par, bclk);
    end
    for (int i = 0; i < stops; i++) begin
      if (bad_stop && i == stops - 1) begin
        // A short low keeps the tail of a bad stop from passing for a new start.
        put_bit(1'b0, bclk * 3 / 4);
        put_bit(1'b1, bclk - bclk * 3 / 4);
      end else begin
        put_bit(1'b1, bclk);
      end
    end
    put_bit(1'b1, bclk);
  endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [6:0] avs_address_i = 7'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic rx_line;
  logic irq_o;
  int bad_count = 0;
  int total_checks = 0;
  int bclk = 32;

  always #12.5 clk_i = ~clk_i;

  urfbd_top i_urfbd_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_i(rx_line), .irq_o(irq_o)
  );
  urfbd_tx_model i_urfbd_tx_model (.clk_i(clk_i), .line_o(rx_line));

  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The request holds until the rising edge that samples waitrequest low.
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= ~w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 50) begin
        chk("bus_timeout", 32'h0, 32'h1);
        end_sim();
      end
      @(posedge clk_i);
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask

  task automatic rd_chk(input string nm, input logic [6:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, e, q);
  endtask

  task automatic get_char(input logic [31:0] e);
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h10;
    while (q[urfbd_pkg::POS_FLAG_EMPTY] !== 1'b0) begin
      bus(1'b0, urfbd_pkg::OFS_FLAGS, 32'h0, 4'hF, q);
      n++;
      if (n > 100) begin
        chk("rx_timeout", 32'h0, 32'h1);
        end_sim();
      end
    end
    rd_chk("rx_data", urfbd_pkg::OFS_RX_DATA, e);
  endtask

  task automatic frame(input logic [7:0] f, input logic [7:0] d, input logic bp,
                       input logic bs, input logic [31:0] e);
    wr(urfbd_pkg::OFS_LINE_FMT, {24'h000000, f});
    i_urfbd_tx_model.send(d, f[6:5] + 5, f[1], f[2], f[7], f[3] + 1, bp, bs, bclk);
    get_char(e);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    rd_chk("line_fmt", urfbd_pkg::OFS_LINE_FMT, 32'h0);
    rd_chk("div_whole", urfbd_pkg::OFS_DIV_WHOLE, 32'h0);
    rd_chk("div_frac", urfbd_pkg::OFS_DIV_FRAC, 32'h0);
    rd_chk("unmapped", 7'h7C, 32'h0);
    wr(urfbd_pkg::OFS_LINE_FMT, 32'hFFFFFFFF);
    rd_chk("line_fmt", urfbd_pkg::OFS_LINE_FMT, 32'h000000FE);
    wr(urfbd_pkg::OFS_DIV_WHOLE, 32'hFFFFABCD);
    rd_chk("div_whole", urfbd_pkg::OFS_DIV_WHOLE, 32'h0000ABCD);
    bus(1'b1, urfbd_pkg::OFS_DIV_WHOLE, 32'h00001200, 4'h2, q);
    rd_chk("div_lane", urfbd_pkg::OFS_DIV_WHOLE, 32'h000012CD);
    wr(urfbd_pkg::OFS_DIV_FRAC, 32'hFFFFFFFF);
    rd_chk("div_frac", urfbd_pkg::OFS_DIV_FRAC, 32'h0000003F);
    wr(urfbd_pkg::OFS_DIV_FRAC, 32'h0);
    wr(urfbd_pkg::OFS_DIV_WHOLE, 32'h2);
  endtask

  task automatic t_formats();
    logic [7:0] pf [4] = '{8'h62, 8'h66, 8'hE6, 8'hE2};
    for (int l = 0; l < 4; l++) begin
      frame({1'b0, l[1:0], 5'h00}, 8'hA5, 1'b0, 1'b0, 32'hA5 & (32'hFF >> (3 - l)));
    end
    for (int p = 0; p < 8; p++) begin
      frame(pf[p / 2], 8'h01, p[0], 1'b0, {22'h0, p[0], 9'h001});
    end
    frame(8'h68, 8'h5A, 1'b0, 1'b0, 32'h05A);
    frame(8'h68, 8'h5A, 1'b0, 1'b1, 32'h15A);
    frame(8'h60, 8'h3C, 1'b0, 1'b1, 32'h13C);
  endtask

  task automatic t_queue();
    wr(urfbd_pkg::OFS_LINE_FMT, 32'h70);
    for (int i = 0; i < 3; i++) begin
      i_urfbd_tx_model.send(8'h30 + i[7:0], 8, 1'b0, 1'b0, 1'b0, 1, 1'b0, 1'b0, bclk);
    end
    for (int i = 0; i < 3; i++) begin
      get_char({24'h0, 8'h30 + i[7:0]});
    end
    wr(urfbd_pkg::OFS_LINE_FMT, 32'h60);
    wr(urfbd_pkg::OFS_IRQ_CLR, 32'hF);
    i_urfbd_tx_model.send(8'h41, 8, 1'b0, 1'b0, 1'b0, 1, 1'b0, 1'b0, bclk);
    i_urfbd_tx_model.send(8'h42, 8, 1'b0, 1'b0, 1'b0, 1, 1'b0, 1'b0, bclk);
    rd_chk("flags_full", urfbd_pkg::OFS_FLAGS, 32'h40);
    get_char(32'h41);
    rd_chk("flags_empty", urfbd_pkg::OFS_FLAGS, 32'h10);
    rd_chk("overrun", urfbd_pkg::OFS_IRQ_STAT, 32'h9);
  endtask

  task automatic t_irq();
    wr(urfbd_pkg::OFS_IRQ_CLR, 32'hF);
    wr(urfbd_pkg::OFS_IRQ_EN, 32'h2);
    frame(8'h62, 8'h01, 1'b0, 1'b0, 32'h001);
    @(negedge clk_i);
    chk("irq_idle", 32'h0, {31'h0, irq_o});
    frame(8'h62, 8'h01, 1'b1, 1'b0, 32'h201);
    @(negedge clk_i);
    chk("irq_set", 32'h1, {31'h0, irq_o});
    rd_chk("irq_stat", urfbd_pkg::OFS_IRQ_STAT, 32'h3);
    wr(urfbd_pkg::OFS_IRQ_EN, 32'h0);
    @(negedge clk_i);
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    wr(urfbd_pkg::OFS_IRQ_EN, 32'h2);
    @(negedge clk_i);
    chk("irq_unmasked", 32'h1, {31'h0, irq_o});
    wr(urfbd_pkg::OFS_IRQ_CLR, 32'h2);
    @(negedge clk_i);
    chk("irq_cleared", 32'h0, {31'h0, irq_o});
    rd_chk("irq_stat", urfbd_pkg::OFS_IRQ_STAT, 32'h1);
  endtask

  // The divisor is rewritten mid-frame; the frame in flight must keep the old rate.
  task automatic t_div();
    wr(urfbd_pkg::OFS_LINE_FMT, 32'h60);
    fork
      i_urfbd_tx_model.send(8'hC3, 8, 1'b0, 1'b0, 1'b0, 1, 1'b0, 1'b0, bclk);
      begin
        repeat (100) @(posedge clk_i);
        wr(urfbd_pkg::OFS_DIV_WHOLE, 32'h3);
      end
    join
    get_char(32'hC3);
    bclk = 48;
    frame(8'h60, 8'h96, 1'b0, 1'b0, 32'h96);
    wr(urfbd_pkg::OFS_CTRL, 32'h1);
    bclk = 24;
    frame(8'h60, 8'h69, 1'b0, 1'b0, 32'h69);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_formats();
    t_queue();
    t_irq();
    t_div();
    end_sim();
  end
endmodule
